/* File: include/crc_calc_regs.vh */
// Register map, field positions, reset values and timing counts of the checksum unit
`ifndef CRC_CALC_REGS_VH
`define CRC_CALC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CHECKSUM_DATA_OFFSET 4'h0
`define SCRATCH_BYTE_OFFSET 4'h4
`define CHECKSUM_CONTROL_OFFSET 4'h8

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define RELOAD_BIT_POS 0
`define SCRATCH_MSB 7
`define CHECKSUM_RESET_VALUE 32'hffff_ffff
`define SCRATCH_RESET_VALUE 8'h00
`define CONTROL_RESET_VALUE 1'b0
`define CRC32_POLY 32'h04c1_1db7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WORD_CYCLES 3'h4
`define BITS_PER_CYCLE 8

`endif

/* File: verification/bus_master_model.sv */
// Register bus master standing in for the processor or DMA
`timescale 1ns/10ps
module bus_master_model (
  input wire ref_clk_in,
  input wire [31:0] rdata_in,
  output reg [3:0] addr_out,
  output reg [31:0] wdata_out,
  output reg write_out,
  output reg read_out
);
  reg [31:0] last_rdata;
  initial {addr_out, wdata_out, write_out, read_out} = 38'h0;
  // One strobe cycle; read data taken in the cycle after, the only cycle it stands
  task op(input [3:0] a, input [31:0] d, input w);
    begin
      addr_out <= a;
      wdata_out <= d;
      write_out <= w;
      read_out <= !w;
      @(posedge ref_clk_in);
      write_out <= 1'b0;
      read_out <= 1'b0;
      #1 last_rdata = rdata_in;
    end
  endtask
endmodule // bus_master_model

/* File: verification/crc_calc_unit_asserts.sv */
// Port assertions for the checksum unit
`timescale 1ns/10ps
module crc_calc_checker (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire write_in,
  input wire read_in,
  input wire [31:0] rdata_out,
  input wire busy_out,
  input wire pending_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_read_idle_zero: assert property (!read_in |=> rdata_out == 0) else $error("idle rdata");
  a_busy_on_write: assert property (write_in && addr_in == 0 && !busy_out && !pending_out &&
    !$past(write_in && addr_in == 8 && wdata_in[0]) |=> busy_out)
    else $error("word not taken");
  a_fold_four: assert property (busy_out [*4] |=> !busy_out) else $error("fold too long");
  // Held word must show up even when the fold ends that cycle
  a_hold_slot: assert property (write_in && addr_in == 0 && busy_out && !pending_out |-> ##[1:2] pending_out)
    else $error("held word lost");
  a_reload_ones: assert property (write_in && addr_in == 8 && wdata_in[0] ##2 read_in && addr_in == 0
    |=> rdata_out == 32'hffff_ffff) else $error("reload value");
  a_reset_ones: assert property ($past(reset_in) && read_in && addr_in == 0
    |=> rdata_out == 32'hffff_ffff) else $error("reset value");
  a_scratch_upper: assert property (read_in && addr_in == 4 |=> rdata_out[31:8] == 0) else $error("scratch");
  a_ctrl_reads_zero: assert property (read_in && addr_in == 8 |=> rdata_out == 0) else $error("control");
endmodule // crc_calc_checker
bind crc_calc_unit crc_calc_checker chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .busy_out(busy_out),
  .pending_out(pending_out));

/* File: verification/test_crc32_calculation_unit.sv */
// Self-checking bench for the checksum unit
`timescale 1ns/10ps
`include "crc_calc_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("unexpected %0t %h %h", $time, g, e); end end
module test_crc32_calculation_unit;
  reg ref_clk_in = 1'b0;
  reg reset_in = 1'b1;
  wire [3:0] addr;
  wire [31:0] wdata, rdata;
  wire write, read, busy, pending;
  int bad_count = 0, checked = 0, i, j;
  reg [31:0] model, w, s;
  always #5 ref_clk_in = ~ref_clk_in;
  bus_master_model m (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .write_out(write), .read_out(read));
  crc_calc_unit dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
    .write_in(write), .read_in(read), .rdata_out(rdata), .busy_out(busy), .pending_out(pending));
  function [31:0] fold(input [31:0] c, input [31:0] d);
    integer k;
    begin
      fold = c;
      for (k = 31; k >= 0; k--) fold = {fold[30:0], 1'b0} ^ ((fold[31] ^ d[k]) ? `CRC32_POLY : 32'h0);
    end
  endfunction
  task report_and_stop;
    begin
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Bounded wait; a stuck engine ends the run
  task settle;
    begin
      @(posedge ref_clk_in);
      #1;
      for (i = 0; i < 12 && (busy !== 1'b0 || pending !== 1'b0); i++) begin @(posedge ref_clk_in); #1; end
      if (i == 12) begin bad_count++; report_and_stop; end
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      m.op(a, 32'h0, 1'b0);
      `CHK(m.last_rdata, e)
    end
  endtask
  initial begin
    void'($urandom(7));
    model = 32'hffff_ffff;
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd(4'h0, model);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0);
    for (j = 0; j < 8; j++) begin
      w = $urandom;
      m.op(4'h0, w, 1'b1);
      rd(4'h0, model);
      model = fold(model, w);
      if (j[0]) begin w = $urandom; m.op(4'h0, w, 1'b1); model = fold(model, w); end
      settle;
      rd(4'h0, model);
    end
    s = $urandom;
    m.op(4'h4, s, 1'b1);
    m.op(4'h0, s, 1'b1);
    m.op(4'h8, 32'h1, 1'b1);
    model = 32'hffff_ffff;
    @(posedge ref_clk_in);
    rd(4'h0, model);
    settle;
    rd(4'h0, 32'hffff_ffff);
    rd(4'h4, {24'h0, s[7:0]});
    rd(4'h8, 32'h0);
    report_and_stop;
  end
endmodule // test_crc32_calculation_unit

/* File: verilog/crc_calc_unit.v */
// Checksum unit top: register port, pending word slot, control and scratch byte
//
// Contract
// - Use CRC-32 generator polynomial 0x04C11DB7
// - Finish each word within four clocks
// - Data register write feeds new word
// - Data register read returns latest result
// - Fold whole word into previous checksum
// - Hold further writes until calculation ends (one word slot only; a further write while busy with the slot full is dropped)
// - Control reload bit loads all ones
// - System reset loads checksum all ones
// - Eight-bit scratch byte, resets to zero
// - Reload leaves scratch byte untouched
// - Reload bit set-only, hardware clears
`timescale 1ns/10ps
`include "crc_calc_regs.vh"

module crc_calc_unit (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire write_in,
  input wire read_in,
  output reg [31:0] rdata_out,
  output reg busy_out,
  output reg pending_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [`SCRATCH_MSB:0] scratch_reg;
  reg reload_reg;
  reg pend_valid_reg;
  reg [31:0] pend_word_reg;
  reg [2:0] slice_reg;
  wire [31:0] checksum;
  wire engine_busy;
  wire wr_data;
  wire wr_scratch;
  wire wr_control;
  wire issue;
  wire [31:0] issue_word;

  assign wr_data = write_in && (addr_in == `CHECKSUM_DATA_OFFSET);
  assign wr_scratch = write_in && (addr_in == `SCRATCH_BYTE_OFFSET);
  assign wr_control = write_in && (addr_in == `CHECKSUM_CONTROL_OFFSET);

  // Oldest word first; engine idle and no reload in flight
  assign issue = !engine_busy && !reload_reg && (pend_valid_reg || wr_data);
  assign issue_word = pend_valid_reg ? pend_word_reg : wdata_in;

  crc_word_engine engine (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .reload_in(reload_reg),
    .start_in(issue),
    .word_in(issue_word),
    .checksum_out(checksum),
    .busy_out(engine_busy)
  );

  // ----------------------------------------------------------------------
  // Slice tracker
  // ----------------------------------------------------------------------
  // Mirrors the engine count so busy_out drops with the engine, not a cycle late
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      slice_reg <= 3'h0;
    end else if (reload_reg) begin
      slice_reg <= 3'h0;
    end else if (issue) begin
      slice_reg <= 3'h1;
    end else if (slice_reg == `WORD_CYCLES) begin
      slice_reg <= 3'h0;
    end else if (slice_reg != 3'h0) begin
      slice_reg <= slice_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Control bit and pending word
  // ----------------------------------------------------------------------
  // One slot only: a third word while busy and slot full is dropped, since
  // the port cannot stall the master
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      reload_reg <= `CONTROL_RESET_VALUE;
      pend_valid_reg <= 1'b0;
      pend_word_reg <= 32'h0000_0000;
    end else begin
      if (wr_control && wdata_in[`RELOAD_BIT_POS]) begin
        reload_reg <= 1'b1;
      end else if (reload_reg) begin
        reload_reg <= 1'b0;
      end
      if (reload_reg || (wr_control && wdata_in[`RELOAD_BIT_POS])) begin
        pend_valid_reg <= 1'b0;
      end else if (pend_valid_reg && issue) begin
        pend_valid_reg <= wr_data;
        pend_word_reg <= wdata_in;
      end else if (wr_data && !issue && !pend_valid_reg) begin
        pend_valid_reg <= 1'b1;
        pend_word_reg <= wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Scratch byte
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      scratch_reg <= `SCRATCH_RESET_VALUE;
    end else if (wr_scratch) begin
      scratch_reg <= wdata_in[`SCRATCH_MSB:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read port and status
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0000_0000;
      busy_out <= 1'b0;
      pending_out <= 1'b0;
    end else begin
      busy_out <= !reload_reg && (issue || (engine_busy && (slice_reg != `WORD_CYCLES)));
      pending_out <= pend_valid_reg;
      rdata_out <= 32'h0000_0000;
      if (read_in) begin
        case (addr_in)
          `CHECKSUM_DATA_OFFSET: begin
            rdata_out <= checksum;
          end
          `SCRATCH_BYTE_OFFSET: begin
            rdata_out <= {24'h00_0000, scratch_reg};
          end
          default: begin
            rdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // crc_calc_unit

/* File: verilog/crc_word_engine.v */
// Running checksum register and the four-cycle word folding engine
`timescale 1ns/10ps
`include "crc_calc_regs.vh"

module crc_word_engine (
  input wire ref_clk_in,
  input wire reset_in,
  input wire reload_in,
  input wire start_in,
  input wire [31:0] word_in,
  output reg [31:0] checksum_out,
  output reg busy_out
);

  // ----------------------------------------------------------------------
  // One byte slice, most significant bit first
  // ----------------------------------------------------------------------
  function [31:0] fold_byte;
    input [31:0] crc;
    input [7:0] data;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 7; i >= 0; i = i - 1) begin
        if (c[31] ^ data[i]) begin
          c = {c[30:0], 1'b0} ^ `CRC32_POLY;
        end else begin
          c = {c[30:0], 1'b0};
        end
      end
      fold_byte = c;
    end
  endfunction

  reg [31:0] work_reg;
  reg [31:0] shift_reg;
  reg [2:0] count_reg;
  wire [31:0] work_next;

  assign work_next = fold_byte(work_reg, shift_reg[31:24]);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Result lands only at the last slice so reads never see a partial value
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      checksum_out <= `CHECKSUM_RESET_VALUE;
      busy_out <= 1'b0;
      work_reg <= 32'h0000_0000;
      shift_reg <= 32'h0000_0000;
      count_reg <= 3'h0;
    end else if (reload_in) begin
      checksum_out <= `CHECKSUM_RESET_VALUE;
      busy_out <= 1'b0;
      count_reg <= 3'h0;
    end else if (busy_out) begin
      work_reg <= work_next;
      shift_reg <= {shift_reg[23:0], 8'h00};
      count_reg <= count_reg + 3'h1;
      if (count_reg == `WORD_CYCLES - 3'h1) begin
        checksum_out <= work_next;
        busy_out <= 1'b0;
      end
    end else if (start_in) begin
      work_reg <= checksum_out;
      shift_reg <= word_in;
      count_reg <= 3'h0;
      busy_out <= 1'b1;
    end
  end

endmodule // crc_word_engine
